/* bench/sla_host.sv */
/*
 Host model: drives the serial line into the loader and samples
 the loader's replies. Assumes 8N1 framing and bit times in clocks.
*/
`timescale 1ns/100ps
module sla_host (
    input  logic clk,
    output logic rxd,
    input  logic txd
);
    // The line idles high between frames
    initial rxd = 1'b1;

    // One frame, LSB first; called just after a falling edge
    task automatic send(input logic [7:0] b, input int bt);
        rxd = 1'b0;
        repeat (bt) @(negedge clk);
        for (int i = 0; i < 9; i++) begin
            rxd = (i < 8) ? b[i] : 1'b1;
            repeat (bt) @(negedge clk);
        end
    endtask

    // Bounded wait for a start bit; a missing reply leaves b unknown
    task automatic recv(output logic [7:0] b, input int bt);
        int n;
        b = 'x;
        n = 0;
        // Sampled on the falling edge, where the loader's line is settled
        while (txd === 1'b1 && n < bt * 40) begin
            n++;
            @(negedge clk);
        end
        if (txd !== 1'b1) begin
            repeat (bt / 2) @(negedge clk);
            for (int i = 0; i < 8; i++) begin
                repeat (bt) @(negedge clk);
                b[i] = txd;
            end
            repeat (bt) @(negedge clk);
        end
    endtask
endmodule // sla_host

/* bench/sla_loader_chk.sv */
/*
 Checker of the loader's ports. Assumes it is bound to sla_loader
 and that the clock enable is held high by its surroundings.
*/
`timescale 1ns/100ps
module sla_loader_chk #(
    parameter AW       = 15,
    parameter USER_TOP = 15'h6fff,
    parameter CW       = 16
) (
    input logic          CLOCK,
    input logic          RST_B,
    input logic          TXD,
    input logic          SYNCED,
    input logic [CW-1:0] BIT_COUNT,
    input logic          RX_VALID,
    input logic          ERASE_BUSY,
    input logic          FL_WE,
    input logic [AW-1:0] FL_ADDR,
    input logic [7:0]    FL_DATA,
    input logic [7:0]    BOOT_STATUS_BYTE,
    input logic [7:0]    SOFTWARE_BOOT_VECTOR,
    input logic [7:0]    SOFTWARE_SECURITY_BYTE,
    input logic [1:0]    SEC_BITS
);
    default clocking @(posedge CLOCK); endclocking
    default disable iff (!RST_B);

    // ---------------------------------------------------------------
    // Assertions
    // ---------------------------------------------------------------
    chk_rx_gated: assert property (!SYNCED |-> !RX_VALID)
        else $error("byte delivered before sync");
    chk_erase_gated: assert property (!SYNCED |-> !ERASE_BUSY)
        else $error("erase before sync");
    chk_sync_sticky: assert property (SYNCED |=> SYNCED)
        else $error("sync lost");
    chk_tx_quiet: assert property (!SYNCED |-> TXD)
        else $error("transmit before sync");
    chk_count_window: assert property ($rose(SYNCED) |->
        BIT_COUNT >= 333 && BIT_COUNT <= 16666)
        else $error("bit count outside window");
    chk_count_held: assert property (SYNCED && $past(SYNCED) |->
        $stable(BIT_COUNT))
        else $error("bit count changed");
    chk_erase_data: assert property (FL_WE |-> FL_DATA == 8'hff)
        else $error("erase data wrong");
    chk_user_only: assert property (FL_WE |-> FL_ADDR <= USER_TOP)
        else $error("write above user region");
    chk_bytes_set: assert property ($fell(ERASE_BUSY) |-> ##1
        BOOT_STATUS_BYTE == 8'hff && SOFTWARE_BOOT_VECTOR == 8'hfc &&
        SOFTWARE_SECURITY_BYTE == 8'hff && SEC_BITS == 2'h0)
        else $error("boot bytes wrong after erase");

    // Main scenarios reached
    cover property ($rose(SYNCED));
    cover property ($fell(ERASE_BUSY));
    cover property (SYNCED && RX_VALID);
endmodule // sla_loader_chk

bind sla_loader sla_loader_chk #(.AW(AW), .USER_TOP(USER_TOP), .CW(CW))
    u_chk (.CLOCK(CLOCK), .RST_B(RST_B), .TXD(TXD), .SYNCED(SYNCED),
    .BIT_COUNT(BIT_COUNT), .RX_VALID(RX_VALID), .ERASE_BUSY(ERASE_BUSY),
    .FL_WE(FL_WE), .FL_ADDR(FL_ADDR), .FL_DATA(FL_DATA),
    .BOOT_STATUS_BYTE(BOOT_STATUS_BYTE),
    .SOFTWARE_BOOT_VECTOR(SOFTWARE_BOOT_VECTOR),
    .SOFTWARE_SECURITY_BYTE(SOFTWARE_SECURITY_BYTE), .SEC_BITS(SEC_BITS));

/* bench/sla_loader_tb.sv */
/*
 Self-checking bench of the loader. Assumes the host model and the
 bound checker; the user region is shortened to keep erase brief.
*/
`timescale 1ns/100ps
module sla_loader_tb;
    localparam int          BT  = 360;
    localparam logic [14:0] TOP = 15'h000f;
    logic        CLOCK, RST_B, CE, RXD, TXD, SYNCED, RX_VALID, RX_READY;
    logic        CSUM_ERR, ERASE_REQ, ERASE_BUSY, FL_WE;
    logic [15:0] BIT_COUNT;
    logic [14:0] FL_ADDR;
    logic [7:0]  RX_DATA, FL_DATA, boot_status_byte, software_boot_vector, software_security_byte, b, d [2];
    logic [1:0]  SEC_BITS;
    int          err_total = 0, check_count = 0, wr_n = 0, wr_bad = 0;

    sla_loader #(.USER_TOP(TOP)) dut (.CLOCK(CLOCK), .RST_B(RST_B),
        .CE(CE), .RXD(RXD), .TXD(TXD), .SYNCED(SYNCED),
        .BIT_COUNT(BIT_COUNT), .RX_DATA(RX_DATA), .RX_VALID(RX_VALID),
        .RX_READY(RX_READY), .CSUM_ERR(CSUM_ERR), .ERASE_REQ(ERASE_REQ),
        .ERASE_BUSY(ERASE_BUSY), .FL_WE(FL_WE), .FL_ADDR(FL_ADDR),
        .FL_DATA(FL_DATA), .BOOT_STATUS_BYTE(boot_status_byte),
        .SOFTWARE_BOOT_VECTOR(software_boot_vector), .SOFTWARE_SECURITY_BYTE(software_security_byte),
        .SEC_BITS(SEC_BITS));
    sla_host u_host (.clk(CLOCK), .rxd(RXD), .txd(TXD));

    // 40 MHz clock
    initial begin
        CLOCK = 1'b0;
        forever #12.5 CLOCK = ~CLOCK;
    end

    // ---------------------------------------------------------------
    // Compare and verdict tasks
    // ---------------------------------------------------------------
    task automatic cmp_val(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("wrong value at %0t: got %h expected %h", $time,
                got, exp);
        end
    endtask

    task automatic cmp_flag(input logic got, input logic exp);
        cmp_val({15'h0000, got}, {15'h0000, exp});
    endtask

    // Expected reply to a checksum failure: X, carriage return, line feed
    function automatic logic [7:0] err_reply(input int i);
        return (i == 0) ? 8'h58 : (i == 1) ? 8'h0d : 8'h0a;
    endfunction

    task automatic give_verdict;
        $display("checks %0d errors %0d", check_count, err_total);
        if (err_total == 0 && check_count > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // Counts flash writes; a stray address or value shows up in wr_bad
    always @(negedge CLOCK) begin
        if (FL_WE === 1'b1) begin
            wr_n++;
            if (FL_ADDR > TOP || FL_DATA !== 8'hff)
                wr_bad++;
        end
    end

    // Watchdog, well beyond the expected run of about 33k cycles
    initial begin
        repeat (95000) @(posedge CLOCK);
        err_total++;
        give_verdict;
    end

    // ---------------------------------------------------------------
    // Main sequence
    // ---------------------------------------------------------------
    initial begin
        CE = 1'b1;
        RST_B = 1'b0;
        RX_READY = 1'b0;
        CSUM_ERR = 1'b0;
        ERASE_REQ = 1'b0;
        void'($urandom(81935));
        repeat (6) @(negedge CLOCK);
        RST_B = 1'b1;
        // A sync character faster than the window must stay unanswered
        u_host.send(8'h55, 100);
        repeat (2000) @(negedge CLOCK);
        cmp_flag(SYNCED, 1'b0);
        cmp_flag(TXD, 1'b1);
        // Retry at a legal rate and expect the echo
        fork
            u_host.send(8'h55, BT);
            u_host.recv(b, BT);
        join
        @(negedge CLOCK);
        cmp_val(b, 8'h55);
        cmp_flag(SYNCED, 1'b1);
        cmp_flag(BIT_COUNT >= BT - 1 && BIT_COUNT <= BT + 1, 1'b1);
        // One random and one corner byte while the receiver stalls
        d[0] = 8'($urandom);
        d[1] = 8'h80;
        fork
            begin
                u_host.send(d[0], BT);
                u_host.send(d[1], BT);
            end
            foreach (d[i]) begin
                u_host.recv(b, BT);
                cmp_val(b, d[i]);
            end
        join
        @(negedge CLOCK);
        foreach (d[i]) begin
            cmp_flag(RX_VALID, 1'b1);
            cmp_val(RX_DATA, d[i]);
            RX_READY = 1'b1;
            @(negedge CLOCK);
            RX_READY = 1'b0;
            repeat (2) @(negedge CLOCK);
        end
        cmp_flag(RX_VALID, 1'b0);
        // Checksum failure reply
        CSUM_ERR = 1'b1;
        @(negedge CLOCK);
        CSUM_ERR = 1'b0;
        for (int i = 0; i < 3; i++) begin
            u_host.recv(b, BT);
            cmp_val(b, err_reply(i));
        end
        // Full erase of the shortened user region
        @(negedge CLOCK);
        ERASE_REQ = 1'b1;
        @(negedge CLOCK);
        ERASE_REQ = 1'b0;
        cmp_flag(ERASE_BUSY, 1'b1);
        for (int n = 0; n < 4000 && ERASE_BUSY !== 1'b0; n++)
            @(negedge CLOCK);
        repeat (2) @(negedge CLOCK);
        cmp_val(wr_n, TOP + 1);
        cmp_val(wr_bad, 0);
        cmp_val({boot_status_byte, software_boot_vector}, 16'hfffc);
        cmp_val({software_security_byte, 6'h00, SEC_BITS}, 16'hff00);
        give_verdict;
    end
endmodule // sla_loader_tb

/* core/sla_loader.v */
/*
 Serial loader front end: autobaud on the sync character, echo, byte
 receive/transmit at the derived rate, checksum-error reply and the
 full-chip-erase sequencer driving a byte-wide flash write port.
 Assumes record parsing sits outside and reports checksum failures
 and erase commands as single-cycle pulses.
*/
`timescale 1ns/100ps
`include "sla_regs.vh"

module sla_loader #(
    parameter AW        = 15,
    parameter USER_TOP  = 15'h6fff,
    parameter CW        = 16
) (
    input  wire          CLOCK,
    input  wire          RST_B,
    input  wire          CE,
    input  wire          RXD,
    output reg           TXD,
    output wire          SYNCED,
    output wire [CW-1:0] BIT_COUNT,
    output wire [7:0]    RX_DATA,
    output wire          RX_VALID,
    input  wire          RX_READY,
    input  wire          CSUM_ERR,
    input  wire          ERASE_REQ,
    output wire          ERASE_BUSY,
    output reg           FL_WE,
    output reg  [AW-1:0] FL_ADDR,
    output reg  [7:0]    FL_DATA,
    output reg  [7:0]    BOOT_STATUS_BYTE,
    output reg  [7:0]    SOFTWARE_BOOT_VECTOR,
    output reg  [7:0]    SOFTWARE_SECURITY_BYTE,
    output reg  [1:0]    SEC_BITS
);

    localparam integer BMAX = `SLA_BIT_MAX;
    localparam integer BMIN = `SLA_BIT_MIN;

    // ---------------------------------------------------------------
    // Input synchroniser
    // ---------------------------------------------------------------
    reg rx_m_q, rx_s_q, rx_p_q;
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            rx_m_q <= 1'b1;
            rx_s_q <= 1'b1;
            rx_p_q <= 1'b1;
        end else if (CE) begin
            rx_m_q <= RXD;
            rx_s_q <= rx_m_q;
            rx_p_q <= rx_s_q;
        end
    end
    wire rx_fall = rx_p_q & ~rx_s_q;

    // ---------------------------------------------------------------
    // Phase machine, autobaud and receiver
    // ---------------------------------------------------------------
    reg [2:0]    st_q;
    reg [CW-1:0] cnt_q, bit_q;
    reg [3:0]    rbit_q;
    reg [7:0]    rsh_q;
    reg          rbusy_q, rstb_q;
    reg [AW-1:0] ea_q;
    reg [1:0]    eph_q;

    // Transmit queue interface
    reg          tq_push;
    reg [7:0]    tq_byte;
    wire         tq_full;
    reg [1:0]    err_q;      // Remaining bytes of the error reply

    assign SYNCED     = (st_q == `SLA_ST_RUN) | (st_q == `SLA_ST_ERASE);
    assign BIT_COUNT  = bit_q;
    assign ERASE_BUSY = (st_q == `SLA_ST_ERASE);

    // Sync U is 0,1,0,1..: low start bit alone gives one bit time
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            st_q <= `SLA_ST_SYNC;
            cnt_q <= {CW{1'b0}};
            bit_q <= BMAX[CW-1:0];
            rbit_q <= 4'h0;
            rsh_q <= 8'h00;
            rbusy_q <= 1'b0;
            rstb_q <= 1'b0;
        end else if (CE) begin
            rstb_q <= 1'b0;
            case (st_q)
                `SLA_ST_SYNC: begin
                    cnt_q <= {CW{1'b0}};
                    rbit_q <= 4'h0;
                    if (rx_fall)
                        st_q <= `SLA_ST_MEAS;
                end
                `SLA_ST_MEAS: begin
                    cnt_q <= cnt_q + 1'b1;
                    if (rx_s_q) begin
                        // Out-of-window widths are dropped; host retries
                        if (cnt_q >= BMIN && cnt_q <= BMAX) begin
                            bit_q <= cnt_q + 1'b1;
                            st_q <= `SLA_ST_ECHO;
                        end else
                            st_q <= `SLA_ST_SYNC;
                    end else if (cnt_q > BMAX)
                        st_q <= `SLA_ST_SYNC;
                end
                `SLA_ST_ECHO: begin
                    // Whole bit times counted, so slow rates cannot wrap
                    cnt_q <= (cnt_q >= bit_q - 1'b1) ? {CW{1'b0}} :
                             cnt_q + 1'b1;
                    if (cnt_q >= bit_q - 1'b1 && rbit_q != `SLA_ECHO_BITS)
                        rbit_q <= rbit_q + 1'b1;
                    if (rbit_q == `SLA_ECHO_BITS && !tq_full)
                        st_q <= `SLA_ST_RUN;
                end
                `SLA_ST_RUN:
                    if (ERASE_REQ)
                        st_q <= `SLA_ST_ERASE;
                `SLA_ST_ERASE:
                    if (eph_q == 2'h3)
                        st_q <= `SLA_ST_RUN;
                default: st_q <= `SLA_ST_SYNC;
            endcase
            // Byte receiver, runs only once the rate is known
            if (st_q == `SLA_ST_RUN || st_q == `SLA_ST_ERASE) begin
                if (!rbusy_q) begin
                    if (rx_fall) begin
                        rbusy_q <= 1'b1;
                        cnt_q <= {1'b0, bit_q[CW-1:1]};
                        rbit_q <= 4'h0;
                    end
                end else if (cnt_q == {CW{1'b0}}) begin
                    cnt_q <= bit_q - 1'b1;
                    rbit_q <= rbit_q + 1'b1;
                    if (rbit_q >= 4'h1 && rbit_q <= `SLA_RX_LAST)
                        rsh_q <= {rx_s_q, rsh_q[7:1]};
                    if (rbit_q == `SLA_RX_STOP) begin
                        rbusy_q <= 1'b0;
                        rstb_q <= rx_s_q;      // Framing error drops byte
                    end
                end else
                    cnt_q <= cnt_q - 1'b1;
            end
        end
    end

    // Two-entry receive buffer; bytes arriving while it is full are lost
    reg [7:0] rb_q [0:1];
    reg       rw_q, rr_q;
    reg [1:0] rn_q;
    wire      rpush = rstb_q && (rn_q != 2'h2);
    wire      rpop  = RX_READY && (rn_q != 2'h0);
    assign RX_DATA  = rb_q[rr_q];
    assign RX_VALID = (rn_q != 2'h0);
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            rw_q <= 1'b0;
            rr_q <= 1'b0;
            rn_q <= 2'h0;
        end else if (CE) begin
            if (rpush) begin
                rb_q[rw_q] <= rsh_q;
                rw_q <= ~rw_q;
            end
            rr_q <= rr_q ^ rpop;
            rn_q <= rn_q + {1'b0, rpush} - {1'b0, rpop};
        end
    end

    // ---------------------------------------------------------------
    // Transmit byte selection: sync echo, error reply, byte echo
    // ---------------------------------------------------------------
    always @* begin
        tq_push = 1'b0;
        tq_byte = 8'h00;
        if (CE && !tq_full) begin
            if (st_q == `SLA_ST_ECHO && rbit_q == `SLA_ECHO_BITS) begin
                tq_push = 1'b1;
                tq_byte = `SLA_CHR_SYNC;
            end else if (err_q != 2'h0) begin
                tq_push = 1'b1;
                tq_byte = (err_q == 2'h3) ? `SLA_CHR_ERR :
                          (err_q == 2'h2) ? `SLA_CHR_CR : `SLA_CHR_LF;
            end else if (rstb_q) begin
                tq_push = 1'b1;
                tq_byte = rsh_q;
            end
        end
    end

    // Error reply sequencer; a new error restarts the reply
    always @(posedge CLOCK) begin
        if (!RST_B)
            err_q <= 2'h0;
        else if (CE) begin
            if (CSUM_ERR && SYNCED)
                err_q <= 2'h3;
            else if (tq_push && err_q != 2'h0 && st_q != `SLA_ST_ECHO)
                err_q <= err_q - 1'b1;
        end
    end

    // ---------------------------------------------------------------
    // Two-entry transmit buffer and serialiser
    // ---------------------------------------------------------------
    reg [7:0] tb_q [0:1];
    reg       tw_q, tr_q;
    reg [1:0] tn_q;
    reg [8:0] tsh_q;
    reg [3:0] tbit_q;
    reg [CW-1:0] tcnt_q;
    wire tbusy = (tbit_q != 4'h0);
    assign tq_full = (tn_q == 2'h2);
    wire pop = !tbusy && tn_q != 2'h0;

    always @(posedge CLOCK) begin
        if (!RST_B) begin
            tw_q <= 1'b0;
            tr_q <= 1'b0;
            tn_q <= 2'h0;
            tsh_q <= 9'h1ff;
            tbit_q <= 4'h0;
            tcnt_q <= {CW{1'b0}};
            TXD <= 1'b1;
        end else if (CE) begin
            if (tq_push) begin
                tb_q[tw_q] <= tq_byte;
                tw_q <= ~tw_q;
            end
            tn_q <= tn_q + {1'b0, tq_push} - {1'b0, pop};
            if (pop) begin
                // Start bit now, then 8 data bits and stop at bit_q rate
                tr_q <= ~tr_q;
                tsh_q <= {1'b1, tb_q[tr_q]};
                TXD <= 1'b0;
                tbit_q <= `SLA_TX_BITS;
                tcnt_q <= bit_q - 1'b1;
            end else if (tbusy) begin
                if (tcnt_q == {CW{1'b0}}) begin
                    tcnt_q <= bit_q - 1'b1;
                    tbit_q <= tbit_q - 1'b1;
                    TXD <= (tbit_q == 4'h1) ? 1'b1 : tsh_q[0];
                    tsh_q <= {1'b1, tsh_q[8:1]};
                end else
                    tcnt_q <= tcnt_q - 1'b1;
            end
        end
    end

    // ---------------------------------------------------------------
    // Full chip erase sequencer
    // ---------------------------------------------------------------
    // Phase 0 fills user flash, 1 writes bootloader bytes, 3 is done
    always @(posedge CLOCK) begin
        if (!RST_B) begin
            ea_q <= {AW{1'b0}};
            eph_q <= 2'h0;
            FL_WE <= 1'b0;
            FL_ADDR <= {AW{1'b0}};
            FL_DATA <= 8'h00;
            BOOT_STATUS_BYTE <= `SLA_BSB_DEF;
            SOFTWARE_BOOT_VECTOR <= `SLA_SBV_DEF;
            SOFTWARE_SECURITY_BYTE <= `SLA_SSB_DEF;
            SEC_BITS <= `SLA_SEC_RESET;
        end else if (CE) begin
            FL_WE <= 1'b0;
            if (st_q == `SLA_ST_ERASE) begin
                case (eph_q)
                    2'h0: begin
                        FL_WE <= 1'b1;
                        FL_ADDR <= ea_q;
                        FL_DATA <= `SLA_ERASED;
                        ea_q <= ea_q + 1'b1;
                        if (ea_q == USER_TOP)
                            eph_q <= 2'h1;
                    end
                    2'h1: begin
                        BOOT_STATUS_BYTE <= `SLA_BSB_DEF;
                        SOFTWARE_BOOT_VECTOR <= `SLA_SBV_DEF;
                        SOFTWARE_SECURITY_BYTE <= `SLA_SSB_DEF;
                        eph_q <= 2'h2;
                    end
                    2'h2: begin
                        SEC_BITS <= `SLA_SEC_CLEAR;
                        eph_q <= 2'h3;
                    end
                    default: begin
                        eph_q <= 2'h0;
                        ea_q <= {AW{1'b0}};
                    end
                endcase
            end
        end
    end

endmodule // sla_loader

/* inc/sla_regs.vh */
/*
 Constants of the serial loader front end: characters, flash image
 values, line-rate window and the loader's phase codes.
 Assumes a 40 MHz core clock and 8N1 framing on the serial line.
*/
`ifndef SLA_REGS_VH
`define SLA_REGS_VH

// ---------------------------------------------------------------
// Characters and flash values
// ---------------------------------------------------------------
`define SLA_CHR_SYNC     8'h55
`define SLA_CHR_ERR      8'h58
`define SLA_CHR_CR       8'h0d
`define SLA_CHR_LF       8'h0a
`define SLA_ERASED       8'hff
`define SLA_BSB_DEF      8'hff
`define SLA_SBV_DEF      8'hfc
`define SLA_SSB_DEF      8'hff
`define SLA_SEC_CLEAR    2'h0
`define SLA_SEC_RESET    2'h3

// ---------------------------------------------------------------
// Line-rate window, in bit/s and in clocks per bit; clock rate in Hz
// ---------------------------------------------------------------
`define SLA_CLK_HZ       40000000
`define SLA_BAUD_MIN     2400
`define SLA_BAUD_MAX     115200
`define SLA_BIT_MAX      (`SLA_CLK_HZ / `SLA_BAUD_MIN)
`define SLA_BIT_MIN      (`SLA_CLK_HZ / `SLA_BAUD_MAX)

// ---------------------------------------------------------------
// Frame timing, in bit positions and bit times
// ---------------------------------------------------------------
`define SLA_TX_BITS      4'ha
`define SLA_RX_LAST      4'h8
`define SLA_RX_STOP      4'h9
`define SLA_ECHO_BITS    4'hf

// ---------------------------------------------------------------
// Phase codes
// ---------------------------------------------------------------
`define SLA_ST_SYNC      3'h0
`define SLA_ST_MEAS      3'h1
`define SLA_ST_ECHO      3'h2
`define SLA_ST_RUN       3'h3
`define SLA_ST_ERASE     3'h4

`endif
